//--- core/tfac_regs.vh
// Register map, fields, header codes and resets
`ifndef TFAC_REGS_VH
`define TFAC_REGS_VH
// APB byte addresses
`define TFAC_ADDR_DEVCTL 8'h00
`define TFAC_ADDR_VCMAP 8'h04
`define TFAC_ADDR_SEV 8'h08
`define TFAC_ADDR_SECONDARY_STATUS_REG 8'h0C
`define TFAC_ADDR_PORT 8'h10
`define TFAC_ADDR_COUNT 8'h14
// Reset values
`define TFAC_RST_DEVCTL 16'h0000
`define TFAC_RST_VCMAP 8'h01
`define TFAC_RST_SEV 32'h00000000
`define TFAC_RST_PORT 9'h000
`define TFAC_RST_SECONDARY_STATUS_REG 16'h0000
// Register fields
`define TFAC_MPS_HI 7
`define TFAC_MPS_LO 5
`define TFAC_MPS_MAX 3'h5
`define TFAC_STA_BIT 11
`define TFAC_ACS_SEV_BIT 21
`define TFAC_PORT_DS_BIT 0
`define TFAC_PORT_ID_HI 8
`define TFAC_PORT_ID_LO 1
// Header dword 0 fields
`define TFAC_FMT_HI 31
`define TFAC_FMT_LO 29
`define TFAC_TYPE_HI 28
`define TFAC_TYPE_LO 24
`define TFAC_TC_HI 22
`define TFAC_TC_LO 20
`define TFAC_TD_BIT 15
`define TFAC_ATTR_HI 13
`define TFAC_ATTR_LO 12
`define TFAC_LEN_HI 9
`define TFAC_LEN_LO 0
// Header dword 1 fields
`define TFAC_MSG_HI 7
`define TFAC_MSG_LO 0
`define TFAC_LBE_HI 7
`define TFAC_LBE_LO 4
// Type codes
`define TFAC_TYPE_MEM 5'h00
`define TFAC_TYPE_MEMLK 5'h01
`define TFAC_TYPE_IO 5'h02
`define TFAC_TYPE_CFG0 5'h04
`define TFAC_TYPE_CFG1 5'h05
`define TFAC_TYPE_CPL 5'h0A
`define TFAC_TYPE_CPLLK 5'h0B
`define TFAC_TYPE_MSG_PFX 2'h2
// Message routing codes
`define TFAC_RT_TO_RC 3'h0
`define TFAC_RT_BCAST 3'h3
`define TFAC_RT_LOCAL 3'h4
`define TFAC_RT_GATHER 3'h5
// Message codes
`define TFAC_MSG_UNLOCK 8'h00
`define TFAC_MSG_PM_NAK 8'h14
`define TFAC_MSG_PM_PME 8'h18
`define TFAC_MSG_PME_OFF 8'h19
`define TFAC_MSG_PME_ACK 8'h1B
`define TFAC_MSG_INTX_PFX 5'h04
`define TFAC_MSG_ERR_COR 8'h30
`define TFAC_MSG_ERR_NF 8'h31
`define TFAC_MSG_ERR_FTL 8'h33
`define TFAC_MSG_SPL 8'h50
`define TFAC_MSG_VDM1 8'h7F
// Sizes in doublewords
`define TFAC_LEN_MAX_DW 11'h400
`define TFAC_MPS_BASE_DW 11'h020
`define TFAC_ONE_DW 11'h001
`define TFAC_HDR3_DW 11'h003
`define TFAC_HDR4_DW 11'h004
`define TFAC_LBE_NONE 4'h0
`endif

//--- core/tfac_hdr_dec.v
// Header decoder for one received TLP: kind, routing and length fields
`timescale 1ns/10ps
`include "tfac_regs.vh"
module tfac_hdr_dec (
    // Header dwords
    input wire [31:0] dw0_in,
    input wire [31:0] dw1_in,
    // Decoded kind
    output reg fmt_ok_out,
    output wire has_data_out,
    output wire is_msg_out,
    output wire is_io_cfg_out,
    output wire is_np_out,
    output wire [2:0] route_out,
    output wire [7:0] msg_code_out,
    // Decoded sizes
    output wire [10:0] len_dw_out,
    output wire [10:0] hdr_dw_out
);
    wire [2:0] fmt; // Format field
    wire [4:0] typ; // Type field
    wire [9:0] len; // Raw length field
    wire is_mem; // Memory request
    wire is_io; // I/O request
    wire is_cfg; // Configuration request

    assign fmt = dw0_in[`TFAC_FMT_HI:`TFAC_FMT_LO];
    assign typ = dw0_in[`TFAC_TYPE_HI:`TFAC_TYPE_LO];
    assign len = dw0_in[`TFAC_LEN_HI:`TFAC_LEN_LO];
    assign has_data_out = fmt[1];
    assign is_msg_out = (typ[4:3] == `TFAC_TYPE_MSG_PFX);
    assign route_out = typ[2:0];
    assign msg_code_out = dw1_in[`TFAC_MSG_HI:`TFAC_MSG_LO];
    assign is_mem = (typ == `TFAC_TYPE_MEM) || (typ == `TFAC_TYPE_MEMLK);
    assign is_io = (typ == `TFAC_TYPE_IO);
    assign is_cfg = (typ == `TFAC_TYPE_CFG0) || (typ == `TFAC_TYPE_CFG1);
    assign is_io_cfg_out = is_io || is_cfg;
    // Memory writes and messages are posted
    assign is_np_out = (is_mem && !fmt[1]) || is_io || is_cfg;
    // Zero length means the largest payload
    assign len_dw_out = (len == 10'h000) ? `TFAC_LEN_MAX_DW : {1'b0, len};
    assign hdr_dw_out = fmt[0] ? `TFAC_HDR4_DW : `TFAC_HDR3_DW;

    // Legal format and type pairs
    always @* begin
        case (typ)
            `TFAC_TYPE_MEM: fmt_ok_out = (fmt[2] == 1'b0);
            `TFAC_TYPE_MEMLK: fmt_ok_out = (fmt[2:1] == 2'b00);
            `TFAC_TYPE_IO,
            `TFAC_TYPE_CFG0,
            `TFAC_TYPE_CFG1,
            `TFAC_TYPE_CPL,
            `TFAC_TYPE_CPLLK: fmt_ok_out = (fmt[2] == 1'b0) && !fmt[0];
            default: fmt_ok_out = is_msg_out && (fmt[2] == 1'b0) && fmt[0]
                && (typ[2:0] <= `TFAC_RT_GATHER);
        endcase
    end
endmodule // tfac_hdr_dec

//--- core/tfac_top.v
// Ingress formation, egress class mapping and access-control checks
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "tfac_regs.vh"
// How it works
// RULE1: Vendor type 1 messages to bridge dropped silently
// RULE2: Every received packet checked before forwarding
// RULE3: Illegal format and type pairs are malformed
// RULE4: Payload above programmed maximum is malformed
// RULE5: Data packets: length field equals payload
// RULE6: Digest packets: total equals header, payload, CRC
// RULE7: I/O, config requests: one dword, zero fields
// RULE8: Listed message kinds must use class zero
// RULE9: Root-bound routing only on downstream ports
// RULE10: Broadcast routing only on upstream ports
// RULE11: Gathered routing only downstream PME acknowledge
// RULE12: Legacy interrupt messages only on downstream ports
// RULE13: Ingress class must map to channel zero
// RULE14: Egress class must map to channel zero
// RULE15: Access checks only in downstream mode
// RULE16: Redirect is no error; block is violation
// RULE17: No source validation on local/gathered messages
// RULE18: Blocked non-posted gets abort completion, flag
// RULE19: Advisory if non-fatal and non-posted, else uncorrectable
// RULE20: Violations log header and drop packet
// RULE21: Direct translated traffic uses peer egress rules
// RULE22: Source violation sets signaled target abort
// RULE23: Formation failures reported malformed with port
module tfac_top (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Received packet header
    input wire rx_valid_in,
    input wire [31:0] rx_dw0_in,
    input wire [31:0] rx_dw1_in,
    input wire [10:0] rx_pay_dw_in,
    input wire [10:0] rx_tot_dw_in,
    input wire rx_to_bridge_in,
    // Access-control results from routing
    input wire acs_src_fail_in,
    input wire acs_xlat_fail_in,
    input wire acs_p2p_egr_fail_in,
    input wire acs_p2p_redir_in,
    // Transmitted packet class
    input wire tx_valid_in,
    input wire [2:0] tx_tc_in,
    // Received packet verdict
    output reg rx_fwd_out,
    output reg rx_drop_out,
    output reg rx_redirect_out,
    output reg vdm1_discard_out,
    // Error reporting
    output reg rx_malformed_out,
    output reg tx_malformed_out,
    output reg tx_ok_out,
    output reg [7:0] err_port_out,
    output reg acs_viol_out,
    output reg acs_corr_out,
    output reg acs_uncorr_out,
    output reg cpl_abort_out,
    output reg hdr_log_out,
    output reg [31:0] hdr_log_dw0_out,
    output reg [31:0] hdr_log_dw1_out,
    output reg sta_out
);
    // Software-visible registers
    reg [15:0] device_control_reg; // Payload size field lives here
    reg [7:0] class_to_channel_map; // Per-class channel 0 enable
    reg [31:0] uncorrectable_severity_reg; // Violation severity bit
    reg [15:0] secondary_status_reg; // Target abort flag, write one clear
    reg [8:0] port_mode; // Downstream flag and port identity
    reg [15:0] malformed_count; // Formation failures seen
    reg [15:0] violation_count; // Access-control violations reported, malformed blocks excluded
    reg [31:0] next_prdata; // Read data for the access phase
    reg next_pslverr; // Unmapped address flag

    // Decoder outputs
    wire fmt_ok;
    wire has_data;
    wire is_msg;
    wire is_io_cfg;
    wire is_np;
    wire [2:0] route;
    wire [7:0] msg_code;
    wire [10:0] len_dw;
    wire [10:0] hdr_dw;

    // Ingress check terms
    wire [2:0] rx_tc; // Class of received packet
    wire downstream; // Port works in downstream mode
    wire [2:0] mps_sel; // Clamped payload size code
    wire [10:0] max_dw; // Largest payload allowed
    wire [10:0] exp_tot_dw; // Length expected with digest
    wire is_intx; // Legacy interrupt message
    wire is_tc0_msg; // Message kinds that need class zero
    wire bad_size; // Length and payload faults
    wire bad_req; // I/O and config field faults
    wire bad_route; // Routing against port direction
    wire bad_class; // Class or channel faults
    wire malformed; // Any formation fault
    wire vdm1_hit; // Vendor type 1 message for this bridge
    wire src_check; // Source validation applies
    wire src_viol; // Source validation block
    wire acs_block; // Any access-control block
    wire acs_report; // Violation that is logged
    wire apb_write; // Write completes this edge
    wire [31:0] sts_clr; // Bits software clears now
    wire sta_set; // Hardware sets target abort

    // Checks whether a class is mapped to channel 0
    function map_hit;
        input [7:0] map;
        input [2:0] tc;
        begin
            map_hit = map[tc];
        end
    endfunction

    // Decode the received header
    tfac_hdr_dec u_dec (
        .dw0_in(rx_dw0_in),
        .dw1_in(rx_dw1_in),
        .fmt_ok_out(fmt_ok),
        .has_data_out(has_data),
        .is_msg_out(is_msg),
        .is_io_cfg_out(is_io_cfg),
        .is_np_out(is_np),
        .route_out(route),
        .msg_code_out(msg_code),
        .len_dw_out(len_dw),
        .hdr_dw_out(hdr_dw)
    );

    assign rx_tc = rx_dw0_in[`TFAC_TC_HI:`TFAC_TC_LO];
    assign downstream = port_mode[`TFAC_PORT_DS_BIT];
    // Large codes would overflow the dword count
    assign mps_sel = (device_control_reg[`TFAC_MPS_HI:`TFAC_MPS_LO] >
        `TFAC_MPS_MAX) ? `TFAC_MPS_MAX :
        device_control_reg[`TFAC_MPS_HI:`TFAC_MPS_LO];
    assign max_dw = `TFAC_MPS_BASE_DW << mps_sel;
    assign exp_tot_dw = hdr_dw + (has_data ? len_dw : 11'h000)
        + `TFAC_ONE_DW;

    assign is_intx = is_msg && (msg_code[7:3] == `TFAC_MSG_INTX_PFX);
    assign is_tc0_msg = is_msg && (is_intx
        || msg_code == `TFAC_MSG_PM_NAK || msg_code == `TFAC_MSG_PM_PME
        || msg_code == `TFAC_MSG_PME_OFF || msg_code == `TFAC_MSG_PME_ACK
        || msg_code == `TFAC_MSG_ERR_COR || msg_code == `TFAC_MSG_ERR_NF
        || msg_code == `TFAC_MSG_ERR_FTL || msg_code == `TFAC_MSG_UNLOCK
        || msg_code == `TFAC_MSG_SPL);

    // Payload checks only when data is carried
    assign bad_size = (has_data && len_dw > max_dw) // [RULE4]
        || (has_data && len_dw != rx_pay_dw_in) // [RULE5]
        || (rx_dw0_in[`TFAC_TD_BIT] && rx_tot_dw_in != exp_tot_dw); // [RULE6]
    assign bad_req = is_io_cfg && (len_dw != `TFAC_ONE_DW
        || rx_tc != 3'h0
        || rx_dw0_in[`TFAC_ATTR_HI:`TFAC_ATTR_LO] != 2'h0
        || rx_dw1_in[`TFAC_LBE_HI:`TFAC_LBE_LO] != `TFAC_LBE_NONE); // [RULE7]
    assign bad_route = is_msg && (
        (route == `TFAC_RT_TO_RC && !downstream) // [RULE9]
        || (route == `TFAC_RT_BCAST && downstream) // [RULE10]
        || (route == `TFAC_RT_GATHER && !(downstream
            && msg_code == `TFAC_MSG_PME_ACK)) // [RULE11]
        || (is_intx && !downstream)); // [RULE12]
    assign bad_class = (is_tc0_msg && rx_tc != 3'h0) // [RULE8]
        || !map_hit(class_to_channel_map, rx_tc); // [RULE13]
    // Any one fault, the pair check included, marks the packet malformed
    assign malformed = !fmt_ok || bad_size || bad_req || bad_route
        || bad_class; // [RULE3]

    assign vdm1_hit = is_msg && rx_to_bridge_in
        && msg_code == `TFAC_MSG_VDM1; // [RULE1]

    // Local and gathered messages skip source validation
    assign src_check = !(is_msg && (route == `TFAC_RT_LOCAL
        || route == `TFAC_RT_GATHER)); // [RULE17]
    assign src_viol = downstream && src_check && acs_src_fail_in; // [RULE15]
    // Direct translated traffic arrives here through the peer terms
    assign acs_block = src_viol || (downstream && (acs_xlat_fail_in
        || acs_p2p_egr_fail_in)); // [RULE15] [RULE21]
    // Malformed outranks a violation in the log
    assign acs_report = acs_block && !malformed;

    assign apb_write = psel_in && penable_in && pready_out && pwrite_in;
    assign sts_clr = (apb_write && paddr_in == `TFAC_ADDR_SECONDARY_STATUS_REG) ?
        pwdata_in : 32'h00000000;
    assign sta_set = rx_valid_in && acs_report
        && (src_viol || is_np); // [RULE22]

    // APB read mux and decode, sampled in the setup cycle
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr_in)
            `TFAC_ADDR_DEVCTL: next_prdata = {16'h0000, device_control_reg};
            `TFAC_ADDR_VCMAP: next_prdata = {24'h000000, class_to_channel_map};
            `TFAC_ADDR_SEV: next_prdata = uncorrectable_severity_reg;
            `TFAC_ADDR_SECONDARY_STATUS_REG: next_prdata = {16'h0000, secondary_status_reg};
            `TFAC_ADDR_PORT: next_prdata = {23'h000000, port_mode};
            `TFAC_ADDR_COUNT: next_prdata = {violation_count, malformed_count};
            default: next_pslverr = 1'b1;
        endcase
    end

    // APB handshake: no wait state, ready in the first access cycle
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h00000000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            if (psel_in && !penable_in) begin
                prdata_out <= pwrite_in ? 32'h00000000 : next_prdata;
                pslverr_out <= next_pslverr;
            end else begin
                prdata_out <= 32'h00000000;
                pslverr_out <= 1'b0;
            end
        end
    end

    // Writable registers
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            device_control_reg <= `TFAC_RST_DEVCTL;
            class_to_channel_map <= `TFAC_RST_VCMAP;
            uncorrectable_severity_reg <= `TFAC_RST_SEV;
            port_mode <= `TFAC_RST_PORT;
        end else if (apb_write) begin
            case (paddr_in)
                `TFAC_ADDR_DEVCTL: device_control_reg <= pwdata_in[15:0];
                `TFAC_ADDR_VCMAP: class_to_channel_map <= pwdata_in[7:0];
                `TFAC_ADDR_SEV: uncorrectable_severity_reg <= pwdata_in;
                `TFAC_ADDR_PORT: port_mode <= pwdata_in[8:0];
                default: port_mode <= port_mode;
            endcase
        end
    end

    // Status flag: hardware set wins over a clear in the same cycle
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            secondary_status_reg <= `TFAC_RST_SECONDARY_STATUS_REG;
        end else if (sta_set) begin
            secondary_status_reg[`TFAC_STA_BIT] <= 1'b1; // [RULE18]
        end else if (sts_clr[`TFAC_STA_BIT]) begin
            secondary_status_reg[`TFAC_STA_BIT] <= 1'b0;
        end
    end

    // Event counters, they wrap rather than saturate
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            malformed_count <= 16'h0000;
            violation_count <= 16'h0000;
        end else begin
            if ((rx_valid_in && malformed) || (tx_valid_in
                && !map_hit(class_to_channel_map, tx_tc_in))) begin
                malformed_count <= malformed_count + 16'h0001;
            end
            if (rx_valid_in && acs_report) begin
                violation_count <= violation_count + 16'h0001;
            end
        end
    end

    // Ingress verdict, one cycle after the header is presented
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_fwd_out <= 1'b0;
            rx_drop_out <= 1'b0;
            rx_redirect_out <= 1'b0;
            vdm1_discard_out <= 1'b0;
            rx_malformed_out <= 1'b0;
            acs_viol_out <= 1'b0;
            acs_corr_out <= 1'b0;
            acs_uncorr_out <= 1'b0;
            cpl_abort_out <= 1'b0;
            hdr_log_out <= 1'b0;
            hdr_log_dw0_out <= 32'h00000000;
            hdr_log_dw1_out <= 32'h00000000;
        end else begin
            // Forward only a packet that passed every check
            rx_fwd_out <= rx_valid_in && !malformed && !acs_block
                && !vdm1_hit; // [RULE2]
            rx_drop_out <= rx_valid_in
                && (malformed || acs_block); // [RULE20]
            // Redirect is silent; a block takes priority over it
            rx_redirect_out <= rx_valid_in && downstream && !malformed
                && !acs_block && !vdm1_hit && acs_p2p_redir_in; // [RULE16]
            // A blocked one is dropped instead, so verdicts stay single
            vdm1_discard_out <= rx_valid_in && vdm1_hit && !malformed
                && !acs_block; // [RULE1]
            rx_malformed_out <= rx_valid_in && malformed; // [RULE23]
            acs_viol_out <= rx_valid_in && acs_report; // [RULE16]
            acs_corr_out <= rx_valid_in && acs_report && is_np
                && !uncorrectable_severity_reg[`TFAC_ACS_SEV_BIT]; // [RULE19]
            acs_uncorr_out <= rx_valid_in && acs_report && !(is_np
                && !uncorrectable_severity_reg[`TFAC_ACS_SEV_BIT]); // [RULE19]
            // Abort completion, never logged as a completer abort
            cpl_abort_out <= rx_valid_in && acs_report && is_np; // [RULE18]
            hdr_log_out <= rx_valid_in
                && (malformed || acs_block); // [RULE20]
            if (rx_valid_in && (malformed || acs_block)) begin
                hdr_log_dw0_out <= rx_dw0_in;
                hdr_log_dw1_out <= rx_dw1_in;
            end
        end
    end

    // Egress class check and the reporting port identity
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_ok_out <= 1'b0;
            tx_malformed_out <= 1'b0;
            err_port_out <= 8'h00;
            sta_out <= 1'b0;
        end else begin
            tx_ok_out <= tx_valid_in
                && map_hit(class_to_channel_map, tx_tc_in); // [RULE14]
            tx_malformed_out <= tx_valid_in
                && !map_hit(class_to_channel_map, tx_tc_in); // [RULE14]
            err_port_out <=
                port_mode[`TFAC_PORT_ID_HI:`TFAC_PORT_ID_LO]; // [RULE23]
            sta_out <= secondary_status_reg[`TFAC_STA_BIT] || sta_set;
        end
    end
endmodule // tfac_top

//--- dv/tfac_props.sv
// Port-level assertions for the packet formation and access checker
`timescale 1ns/10ps
module tfac_props (
    // Clock, reset and stimulus
    input wire core_clk_in,
    input wire rst_in,
    input wire rx_valid_in,
    input wire [31:0] rx_dw0_in,
    input wire acs_src_fail_in,
    input wire acs_xlat_fail_in,
    input wire acs_p2p_egr_fail_in,
    input wire tx_valid_in,
    // Verdicts and reports
    input wire rx_fwd_out,
    input wire rx_drop_out,
    input wire rx_redirect_out,
    input wire vdm1_discard_out,
    input wire rx_malformed_out,
    input wire tx_malformed_out,
    input wire tx_ok_out,
    input wire acs_viol_out,
    input wire acs_corr_out,
    input wire acs_uncorr_out,
    input wire cpl_abort_out,
    input wire hdr_log_out,
    input wire [31:0] hdr_log_dw0_out,
    input wire sta_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Any blocking term offered by routing
    wire any_fail = acs_src_fail_in | acs_xlat_fail_in | acs_p2p_egr_fail_in;
    one_verdict_a: assert property (rx_valid_in |=>
        $onehot({rx_fwd_out, rx_drop_out, vdm1_discard_out}))
        else $error("received header without a single verdict");
    idle_quiet_a: assert property (!rx_valid_in |=>
        !rx_fwd_out && !rx_drop_out && !acs_viol_out)
        else $error("verdict without a received header");
    mal_drop_a: assert property (rx_malformed_out |->
        rx_drop_out && !rx_fwd_out && !acs_viol_out)
        else $error("malformed packet not dropped");
    vdm_silent_a: assert property (vdm1_discard_out |->
        !rx_malformed_out && !hdr_log_out && !cpl_abort_out)
        else $error("vendor message discard raised an error");
    tx_verdict_a: assert property (tx_valid_in |=>
        tx_ok_out ^ tx_malformed_out)
        else $error("egress class verdict missing or doubled");
    redir_clean_a: assert property (rx_redirect_out |->
        !acs_viol_out && !hdr_log_out)
        else $error("redirect logged as an error");
    viol_cause_a: assert property (acs_viol_out |->
        $past(any_fail) && rx_drop_out && hdr_log_out)
        else $error("violation without cause, drop or log");
    viol_kind_a: assert property (acs_viol_out |->
        acs_corr_out ^ acs_uncorr_out)
        else $error("violation class not exactly one");
    abort_np_a: assert property (acs_corr_out |->
        cpl_abort_out && acs_viol_out && sta_out)
        else $error("advisory case without abort completion");
    log_hdr_a: assert property (hdr_log_out |->
        hdr_log_dw0_out == $past(rx_dw0_in))
        else $error("logged header differs from received one");
endmodule // tfac_props
bind tfac_top tfac_props u_props (.*);

//--- dv/tfac_link.sv
// Link partner model presenting received packet headers
`timescale 1ns/10ps
module tfac_link (
    // Clock
    input wire core_clk_in,
    // Header toward the checker
    output reg rx_valid_out,
    output reg [31:0] rx_dw0_out,
    output reg [31:0] rx_dw1_out,
    output reg [10:0] rx_pay_dw_out,
    output reg [10:0] rx_tot_dw_out
);
    // Idle link at time zero
    initial begin
        {rx_valid_out, rx_dw0_out, rx_dw1_out, rx_pay_dw_out,
            rx_tot_dw_out} = 87'h0;
    end
    // One header per call; lines then inverted so stale ones never pass
    task send(input [31:0] d0, input [31:0] d1, input [10:0] p,
              input [10:0] t);
        {rx_valid_out, rx_dw0_out, rx_dw1_out, rx_pay_dw_out,
            rx_tot_dw_out} <= {1'b1, d0, d1, p, t};
        @(posedge core_clk_in);
        {rx_valid_out, rx_dw0_out, rx_dw1_out, rx_pay_dw_out,
            rx_tot_dw_out} <= {1'b0, ~d0, ~d1, ~p, ~t};
    endtask
endmodule // tfac_link

//--- dv/tfac_top_tb.sv
// Self-checking bench for the packet formation and access checker
`timescale 1ns/10ps
`include "tfac_regs.vh"
module tfac_top_tb;
    // Design ports, same names for hookup
    logic core_clk_in, rst_in, psel_in, penable_in, pwrite_in;
    logic [7:0] paddr_in, err_port_out;
    logic [31:0] pwdata_in, prdata_out, rx_dw0_in, rx_dw1_in, q;
    logic [31:0] hdr_log_dw0_out, hdr_log_dw1_out;
    logic [10:0] rx_pay_dw_in, rx_tot_dw_in;
    logic [2:0] tx_tc_in;
    logic pready_out, pslverr_out, rx_valid_in, rx_to_bridge_in, se;
    logic acs_src_fail_in, acs_xlat_fail_in, acs_p2p_egr_fail_in;
    logic acs_p2p_redir_in, tx_valid_in, rx_fwd_out, rx_drop_out;
    logic rx_redirect_out, vdm1_discard_out, rx_malformed_out;
    logic tx_malformed_out, tx_ok_out, acs_viol_out, acs_corr_out;
    logic acs_uncorr_out, cpl_abort_out, hdr_log_out, sta_out;
    int failures = 0;
    int samples_checked = 0;
    logic [3:0] ac = 4'h0;
    logic br = 1'b0;
    // Verdict bits: fwd drop redir vdm mal viol corr unc cpl log
    wire [9:0] vd = {rx_fwd_out, rx_drop_out, rx_redirect_out,
        vdm1_discard_out, rx_malformed_out, acs_viol_out, acs_corr_out,
        acs_uncorr_out, cpl_abort_out, hdr_log_out};
    localparam [9:0] v_ok = 10'h200;
    localparam [9:0] v_mal = 10'h121;
    tfac_top dut (.*);
    tfac_link link (.core_clk_in(core_clk_in), .rx_valid_out(rx_valid_in),
        .rx_dw0_out(rx_dw0_in), .rx_dw1_out(rx_dw1_in),
        .rx_pay_dw_out(rx_pay_dw_in), .rx_tot_dw_out(rx_tot_dw_in));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    // Message header, 4 dwords, no data
    function automatic [31:0] mh(input [2:0] r, input [2:0] c);
        mh = {3'h1, 2'h2, r, 1'b0, c, 20'h00000};
    endfunction
    task chk(input logic [32:0] g, input logic [32:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One APB transfer; the wait for pready is bounded
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_in);
        {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        {q, se} = {prdata_out, pslverr_out};
        {psel_in, penable_in} <= 2'h0;
        if (pready_out !== 1'b1) begin
            failures++;
            tally_and_finish;
        end
    endtask
    // Send one header, check the masked verdict
    task pkt(input logic [31:0] d0, input logic [31:0] d1,
        input logic [9:0] e, input logic [10:0] p = 11'h000,
        input logic [9:0] m = 10'h3FF, input logic [10:0] bad = 11'h000);
        logic [10:0] t;
        t = (d0[29] ? 11'h004 : 11'h003) + p + d0[15] + bad;
        @(posedge core_clk_in);
        {acs_src_fail_in, acs_xlat_fail_in, acs_p2p_egr_fail_in,
            acs_p2p_redir_in, rx_to_bridge_in} <= {ac, br};
        link.send(d0, d1, p, t);
        #1;
        chk(m & vd, e);
    endtask
    initial begin
        {rst_in, psel_in, penable_in, pwrite_in, tx_valid_in} = 5'h10;
        {paddr_in, pwdata_in, tx_tc_in} = 43'h0;
        {acs_src_fail_in, acs_xlat_fail_in, acs_p2p_egr_fail_in,
            acs_p2p_redir_in, rx_to_bridge_in} = 5'h00;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        apb(1'b0, `TFAC_ADDR_VCMAP, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk({q, se}, 33'h1);
        $display("test registers done");
        // Upstream port, payload limit 32 dwords, only class 0 mapped
        pkt(32'h40000020, 32'hFF, v_ok, 11'h020);
        pkt(32'h40000021, 32'hFF, v_mal, 11'h021);
        pkt(32'h40000004, 32'hFF, v_mal, 11'h005);
        pkt(32'h00008001, 32'hFF, v_ok);
        pkt(32'h00008001, 32'hFF, v_mal, 11'h0, 10'h3FF, 11'h1);
        pkt(32'h03000001, 32'h0F, v_mal);
        pkt(32'h02000001, 32'h0F, v_ok);
        pkt(32'h02000002, 32'h0F, v_mal);
        pkt(32'h04001001, 32'h0F, v_mal);
        pkt(32'h05000001, 32'h1F, v_mal);
        pkt(32'h00100001, 32'hFF, v_mal);
        for (int c = 0; c < 8; c++) begin
            @(posedge core_clk_in);
            {tx_valid_in, tx_tc_in} <= {1'b1, c[2:0]};
            @(posedge core_clk_in);
            tx_valid_in <= 1'b0;
            #1;
            chk({tx_ok_out, tx_malformed_out}, (c == 0) ? 2'h2 : 2'h1);
        end
        $display("test formation done");
        apb(1'b1, `TFAC_ADDR_VCMAP, 32'hFF);
        pkt(32'h00100001, 32'hFF, v_ok);
        pkt(mh(3'h3, 3'h0), 32'h00, v_ok);
        pkt(mh(3'h3, 3'h1), 32'h00, v_mal);
        pkt(mh(3'h3, 3'h1), 32'h50, v_mal);
        pkt(mh(3'h0, 3'h0), 32'h30, v_mal);
        pkt(mh(3'h4, 3'h0), 32'h20, v_mal);
        pkt(mh(3'h5, 3'h0), 32'h1B, v_mal);
        apb(1'b1, `TFAC_ADDR_PORT, 32'hB5);
        pkt(mh(3'h0, 3'h0), 32'h31, v_ok);
        chk(err_port_out, 32'h5A);
        pkt(mh(3'h0, 3'h1), 32'h18, v_mal);
        pkt(mh(3'h3, 3'h0), 32'h00, v_mal);
        pkt(mh(3'h5, 3'h0), 32'h1B, v_ok);
        pkt(mh(3'h5, 3'h0), 32'h19, v_mal);
        pkt(mh(3'h4, 3'h1), 32'h20, v_mal);
        br = 1'b1;
        pkt(mh(3'h4, 3'h0), 32'h7F, 10'h040);
        {br, ac} = {1'b0, 4'h8};
        pkt(mh(3'h4, 3'h0), 32'h20, v_ok);
        $display("test routing done");
        pkt(32'h00000001, 32'hFF, 10'h11B);
        chk(sta_out, 32'h1);
        chk(hdr_log_dw0_out, 32'h00000001);
        apb(1'b0, `TFAC_ADDR_SECONDARY_STATUS_REG, 32'h0);
        chk(q[11], 32'h1);
        apb(1'b1, `TFAC_ADDR_SECONDARY_STATUS_REG, 32'h800);
        apb(1'b0, `TFAC_ADDR_SECONDARY_STATUS_REG, 32'h0);
        chk(q[11], 32'h0);
        pkt(32'h40000001, 32'hFF, 10'h115, 11'h001);
        apb(1'b1, `TFAC_ADDR_SEV, 32'h00200000);
        ac = 4'h4;
        pkt(32'h00000001, 32'hFF, 10'h117);
        ac = 4'h2;
        pkt(32'h00000001, 32'hFF, 10'h117);
        ac = 4'h1;
        pkt(32'h40000001, 32'hFF, 10'h080, 11'h001, 10'h0B0);
        apb(1'b1, `TFAC_ADDR_PORT, 32'h0);
        ac = 4'h8;
        pkt(32'h00000001, 32'hFF, v_ok);
        $display("test access control done");
        tally_and_finish;
    end
endmodule // tfac_top_tb
